// File: hdl/brd_defs.vh
// Offsets, field positions and reset values of the range decode block.
// Assumes inclusion by bare name from the design files.
`ifndef BRD_DEFS_VH
`define BRD_DEFS_VH

// Configuration offsets, byte addresses
`define BRD_OFF_FB_SIZE     8'h84
`define BRD_OFF_GAP_START   8'h88
`define BRD_OFF_GAP_END     8'h8C
`define BRD_OFF_IO_ONE      8'h98
`define BRD_OFF_IO_TWO      8'hA0
`define BRD_OFF_STATUS      8'hAC

// Gap start fields
`define BRD_GAP_EN_BIT      31
`define BRD_GAP_FIELD_HI    15
`define BRD_GAP_FIELD_LO    0

// I/O window fields
`define BRD_IO_END_HI       31
`define BRD_IO_END_LO       20
`define BRD_IO_START_HI     15
`define BRD_IO_START_LO     4
`define BRD_IO_EN_BIT       0

// Memory address slice, host and PCI side, compared with the gap fields
`define BRD_MEM_ADDR_HI     35
`define BRD_MEM_ADDR_LO     20
// I/O address slice compared with the window fields
`define BRD_IO_ADDR_HI      15
`define BRD_IO_ADDR_LO      4

// Writable bit masks, reserved bits stay zero
`define BRD_MASK_FB_SIZE    32'h0000001F
`define BRD_MASK_GAP_START  32'h8000FFFF
`define BRD_MASK_GAP_END    32'h0000FFFF
`define BRD_MASK_IO         32'hFFF0FFF1

// Reset values
`define BRD_RST_FB_SIZE     32'h00000000
`define BRD_RST_GAP_START   32'h00000000
`define BRD_RST_GAP_END     32'h00000000
`define BRD_RST_IO_PRIMARY  32'hFFF00001
`define BRD_RST_IO_SECOND   32'hFFF00000

// Frame buffer size codes
`define BRD_FB_CODE_1MB     5'h00
`define BRD_FB_CODE_2MB     5'h01
`define BRD_FB_CODE_4MB     5'h03
`define BRD_FB_CODE_8MB     5'h07
`define BRD_FB_CODE_16MB    5'h0F
`define BRD_FB_CODE_32MB    5'h1F

`endif

// File: hdl/brd_window_match.v
// Inclusive range comparator for one address window.
// Assumes low and high boundaries already sliced to the compare width.
`timescale 1ns/1ps
module brd_window_match #(
  parameter W = 16
) (
  input  wire [W-1:0] addr,
  input  wire [W-1:0] low,
  input  wire [W-1:0] high,
  output wire         hit
);

  // Inside when low <= addr <= high
  assign hit = (addr >= low) && (addr <= high);  // see [RULE18]

endmodule

// File: hdl/brd_fb_size.v
// Frame buffer size code decoder.
// Assumes the code comes from a register on the same clock.
`timescale 1ns/1ps
`include "brd_defs.vh"
module brd_fb_size (
  input  wire [4:0] code,
  output reg  [5:0] size_mb,
  output reg        reserved
);

  // Map each legal code to megabytes, flag the rest
  always @* begin
    size_mb  = 6'h00;
    reserved = 1'b0;
    case (code)  // see [RULE1]
      `BRD_FB_CODE_1MB:  size_mb = 6'h01;
      `BRD_FB_CODE_2MB:  size_mb = 6'h02;
      `BRD_FB_CODE_4MB:  size_mb = 6'h04;
      `BRD_FB_CODE_8MB:  size_mb = 6'h08;
      `BRD_FB_CODE_16MB: size_mb = 6'h10;
      `BRD_FB_CODE_32MB: size_mb = 6'h20;
      default: begin
        size_mb  = 6'h00;
        reserved = 1'b1;
      end
    endcase
  end

endmodule

// File: hdl/brd_range_decode.v
// Address range decode for a host to PCI bridge: high memory gap,
// two I/O windows, frame buffer size, written over configuration space.
// Assumes request strobes and addresses come from logic on CLK_SYS.
`timescale 1ns/1ps
`include "brd_defs.vh"

// What this block does
// [RULE1] Decode five-bit frame buffer size code
// [RULE2] Enabled gap: host to PCI, PCI blocked
// [RULE3] Disabled gap: host blocked, PCI to host
// [RULE4] Gap start bit 31 enables gap
// [RULE5] Gap start field matches A[35:20]
// [RULE6] All-zero gap start disables range
// [RULE7] Gap end field matches A[35:20]
// [RULE8] Software writes zero to reserved bits
// [RULE9] Window one end matches A[15:4]
// [RULE10] Window one start matches A[15:4]
// [RULE11] Software programs both bridges identically
// [RULE12] Window enabled: host to PCI, PCI ignored
// [RULE13] Window disabled: host ignored, PCI forwarded
// [RULE14] Outside windows: direction set by bridge role
// [RULE15] Second I/O window works the same
// [RULE16] Primary window one resets to FFF00001
// [RULE17] Secondary window one resets to FFF00000
// [RULE18] Inside means start <= address <= end
// [RULE19] Windows decode independently, first match wins
module brd_range_decode #(
  parameter PRIMARY = 1
) (
  input  wire        CLK_SYS,
  input  wire        RESET,
  input  wire        CFG_WR,
  input  wire        CFG_RD,
  input  wire [7:0]  CFG_ADDR,
  input  wire [3:0]  CFG_BE,
  input  wire [31:0] CFG_WDATA,
  output reg  [31:0] CFG_RDATA,
  output reg         CFG_RACK,
  input  wire        HOST_MEM_REQ,
  input  wire [35:0] HOST_MEM_ADDR,
  output reg         HOST_MEM_DONE,
  output reg         HOST_MEM_HIT,
  output reg         HOST_MEM_FWD,
  input  wire        PCI_MEM_REQ,
  input  wire [35:0] PCI_MEM_ADDR,
  output reg         PCI_MEM_DONE,
  output reg         PCI_MEM_HIT,
  output reg         PCI_MEM_FWD,
  input  wire        HOST_IO_REQ,
  input  wire [15:0] HOST_IO_ADDR,
  output reg         HOST_IO_DONE,
  output reg         HOST_IO_FWD,
  input  wire        PCI_IO_REQ,
  input  wire [15:0] PCI_IO_ADDR,
  output reg         PCI_IO_DONE,
  output reg         PCI_IO_FWD,
  output reg         GAP_ENABLE,
  output reg  [5:0]  FB_SIZE_MB,
  output reg         FB_SIZE_BAD
);

  // Window one and two reset value depends on bridge role
  localparam [31:0] IO_RST = (PRIMARY != 0) ? `BRD_RST_IO_PRIMARY
                                            : `BRD_RST_IO_SECOND;
  localparam [0:0]  IS_PRIMARY = (PRIMARY != 0) ? 1'b1 : 1'b0;

  // Configuration registers
  reg  [31:0] fb_size_reg;
  reg  [31:0] gap_start;
  reg  [31:0] gap_end;
  reg  [31:0] io_window_one;
  reg  [31:0] io_window_two;

  // Byte lane mask from the byte enables
  wire [31:0] lane_mask;

  // Register selects
  wire        sel_fb;
  wire        sel_gs;
  wire        sel_ge;
  wire        sel_io1;
  wire        sel_io2;
  wire        sel_st;

  // Field views
  wire        gap_en;
  wire [15:0] gap_lo;
  wire [15:0] gap_hi;
  wire        gap_range_on;
  wire [11:0] io1_lo;
  wire [11:0] io1_hi;
  wire        io1_en;
  wire [11:0] io2_lo;
  wire [11:0] io2_hi;
  wire        io2_en;

  // Compare results
  wire        host_gap_in;
  wire        pci_gap_in;
  wire        host_io1_in;
  wire        host_io2_in;
  wire        pci_io1_in;
  wire        pci_io2_in;

  // Frame buffer decode
  wire [5:0]  fb_mb;
  wire        fb_bad;

  // Next values of the decision outputs
  reg         next_host_mem_hit;
  reg         next_host_mem_fwd;
  reg         next_pci_mem_hit;
  reg         next_pci_mem_fwd;
  reg         next_host_io_fwd;
  reg         next_pci_io_fwd;
  reg  [31:0] next_rdata;
  wire [31:0] status_word;

  // One lane mask bit group per byte enable
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_lane
      assign lane_mask[8*i+7:8*i] = {8{CFG_BE[i]}};
    end
  endgenerate

  // Word aligned address decode
  assign sel_fb  = ({CFG_ADDR[7:2], 2'b00} == `BRD_OFF_FB_SIZE);
  assign sel_gs  = ({CFG_ADDR[7:2], 2'b00} == `BRD_OFF_GAP_START);
  assign sel_ge  = ({CFG_ADDR[7:2], 2'b00} == `BRD_OFF_GAP_END);
  assign sel_io1 = ({CFG_ADDR[7:2], 2'b00} == `BRD_OFF_IO_ONE);
  assign sel_io2 = ({CFG_ADDR[7:2], 2'b00} == `BRD_OFF_IO_TWO);
  assign sel_st  = ({CFG_ADDR[7:2], 2'b00} == `BRD_OFF_STATUS);

  // Gap fields
  assign gap_en = gap_start[`BRD_GAP_EN_BIT];  // see [RULE4]
  assign gap_lo = gap_start[`BRD_GAP_FIELD_HI:`BRD_GAP_FIELD_LO];  // see [RULE5]
  assign gap_hi = gap_end[`BRD_GAP_FIELD_HI:`BRD_GAP_FIELD_LO];  // see [RULE7]
  // Zero start field kills the range whatever else is set
  assign gap_range_on = (gap_lo != 16'h0000);  // see [RULE6]

  // Window one fields
  assign io1_hi = io_window_one[`BRD_IO_END_HI:`BRD_IO_END_LO];  // see [RULE9]
  assign io1_lo = io_window_one[`BRD_IO_START_HI:`BRD_IO_START_LO];  // see [RULE10]
  assign io1_en = io_window_one[`BRD_IO_EN_BIT];

  // Window two fields, same layout
  assign io2_hi = io_window_two[`BRD_IO_END_HI:`BRD_IO_END_LO];  // see [RULE15]
  assign io2_lo = io_window_two[`BRD_IO_START_HI:`BRD_IO_START_LO];
  assign io2_en = io_window_two[`BRD_IO_EN_BIT];

  // Host side gap compare
  brd_window_match #(.W(16)) u_host_gap (
    .addr (HOST_MEM_ADDR[`BRD_MEM_ADDR_HI:`BRD_MEM_ADDR_LO]),
    .low  (gap_lo),
    .high (gap_hi),
    .hit  (host_gap_in)
  );

  // PCI side gap compare
  brd_window_match #(.W(16)) u_pci_gap (
    .addr (PCI_MEM_ADDR[`BRD_MEM_ADDR_HI:`BRD_MEM_ADDR_LO]),
    .low  (gap_lo),
    .high (gap_hi),
    .hit  (pci_gap_in)
  );

  // Host side window one compare
  brd_window_match #(.W(12)) u_host_io1 (
    .addr (HOST_IO_ADDR[`BRD_IO_ADDR_HI:`BRD_IO_ADDR_LO]),
    .low  (io1_lo),
    .high (io1_hi),
    .hit  (host_io1_in)
  );

  // Host side window two compare
  brd_window_match #(.W(12)) u_host_io2 (
    .addr (HOST_IO_ADDR[`BRD_IO_ADDR_HI:`BRD_IO_ADDR_LO]),
    .low  (io2_lo),
    .high (io2_hi),
    .hit  (host_io2_in)
  );

  // PCI side window one compare
  brd_window_match #(.W(12)) u_pci_io1 (
    .addr (PCI_IO_ADDR[`BRD_IO_ADDR_HI:`BRD_IO_ADDR_LO]),
    .low  (io1_lo),
    .high (io1_hi),
    .hit  (pci_io1_in)
  );

  // PCI side window two compare
  brd_window_match #(.W(12)) u_pci_io2 (
    .addr (PCI_IO_ADDR[`BRD_IO_ADDR_HI:`BRD_IO_ADDR_LO]),
    .low  (io2_lo),
    .high (io2_hi),
    .hit  (pci_io2_in)
  );

  // Frame buffer size decode
  brd_fb_size u_fb (
    .code     (fb_size_reg[4:0]),
    .size_mb  (fb_mb),
    .reserved (fb_bad)
  );

  // Memory gap forwarding decisions
  always @* begin
    next_host_mem_hit = host_gap_in & gap_range_on;
    next_pci_mem_hit  = pci_gap_in & gap_range_on;
    // Enabled: host passes, PCI blocked; disabled: the reverse
    next_host_mem_fwd = next_host_mem_hit & gap_en;   // see [RULE2]
    next_pci_mem_fwd  = next_pci_mem_hit & ~gap_en;   // see [RULE3]
  end

  // Host I/O forwarding, window one checked first
  always @* begin
    if (host_io1_in) begin
      next_host_io_fwd = io1_en;  // see [RULE12] [RULE13]
    end else if (host_io2_in) begin
      next_host_io_fwd = io2_en;  // see [RULE15] [RULE19]
    end else begin
      next_host_io_fwd = IS_PRIMARY;  // see [RULE14]
    end
  end

  // PCI I/O forwarding, window one checked first
  always @* begin
    if (pci_io1_in) begin
      next_pci_io_fwd = ~io1_en;  // see [RULE12] [RULE13]
    end else if (pci_io2_in) begin
      next_pci_io_fwd = ~io2_en;  // see [RULE19]
    end else begin
      next_pci_io_fwd = ~IS_PRIMARY;  // see [RULE14]
    end
  end

  // Status word shows last decisions and role
  assign status_word = {15'h0000, FB_SIZE_BAD, 2'h0, FB_SIZE_MB,
                        1'b0, IS_PRIMARY, PCI_IO_FWD, HOST_IO_FWD,
                        PCI_MEM_FWD, PCI_MEM_HIT, HOST_MEM_FWD,
                        HOST_MEM_HIT};

  // Read mux, unmapped offsets read zero
  always @* begin
    next_rdata = 32'h00000000;
    if (sel_fb) begin
      next_rdata = fb_size_reg;
    end else if (sel_gs) begin
      next_rdata = gap_start;
    end else if (sel_ge) begin
      next_rdata = gap_end;
    end else if (sel_io1) begin
      next_rdata = io_window_one;
    end else if (sel_io2) begin
      next_rdata = io_window_two;
    end else if (sel_st) begin
      next_rdata = status_word;
    end
  end

  // Configuration writes, reserved bits never stored
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      fb_size_reg   <= `BRD_RST_FB_SIZE;
      gap_start     <= `BRD_RST_GAP_START;
      gap_end       <= `BRD_RST_GAP_END;
      io_window_one <= IO_RST;  // see [RULE16] [RULE17]
      io_window_two <= IO_RST;
    end else if (CFG_WR) begin
      if (sel_fb) begin
        fb_size_reg <= (fb_size_reg & ~(lane_mask & `BRD_MASK_FB_SIZE))
                     | (CFG_WDATA & lane_mask & `BRD_MASK_FB_SIZE);
      end
      if (sel_gs) begin
        gap_start <= (gap_start & ~(lane_mask & `BRD_MASK_GAP_START))
                   | (CFG_WDATA & lane_mask & `BRD_MASK_GAP_START);
      end
      if (sel_ge) begin
        gap_end <= (gap_end & ~(lane_mask & `BRD_MASK_GAP_END))
                 | (CFG_WDATA & lane_mask & `BRD_MASK_GAP_END);
      end
      if (sel_io1) begin
        io_window_one <= (io_window_one & ~(lane_mask & `BRD_MASK_IO))
                       | (CFG_WDATA & lane_mask & `BRD_MASK_IO);
      end
      if (sel_io2) begin
        io_window_two <= (io_window_two & ~(lane_mask & `BRD_MASK_IO))
                       | (CFG_WDATA & lane_mask & `BRD_MASK_IO);
      end
    end
  end

  // Read answer one cycle after the strobe
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      CFG_RDATA <= 32'h00000000;
      CFG_RACK  <= 1'b0;
    end else begin
      CFG_RACK <= CFG_RD;
      if (CFG_RD) begin
        CFG_RDATA <= next_rdata;
      end
    end
  end

  // Memory decisions, held until the next request
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      HOST_MEM_DONE <= 1'b0;
      HOST_MEM_HIT  <= 1'b0;
      HOST_MEM_FWD  <= 1'b0;
      PCI_MEM_DONE  <= 1'b0;
      PCI_MEM_HIT   <= 1'b0;
      PCI_MEM_FWD   <= 1'b0;
    end else begin
      HOST_MEM_DONE <= HOST_MEM_REQ;
      PCI_MEM_DONE  <= PCI_MEM_REQ;
      if (HOST_MEM_REQ) begin
        HOST_MEM_HIT <= next_host_mem_hit;
        HOST_MEM_FWD <= next_host_mem_fwd;  // see [RULE2] [RULE3]
      end
      if (PCI_MEM_REQ) begin
        PCI_MEM_HIT <= next_pci_mem_hit;
        PCI_MEM_FWD <= next_pci_mem_fwd;  // see [RULE2] [RULE3]
      end
    end
  end

  // I/O decisions, held until the next request
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      HOST_IO_DONE <= 1'b0;
      HOST_IO_FWD  <= 1'b0;
      PCI_IO_DONE  <= 1'b0;
      PCI_IO_FWD   <= 1'b0;
    end else begin
      HOST_IO_DONE <= HOST_IO_REQ;
      PCI_IO_DONE  <= PCI_IO_REQ;
      if (HOST_IO_REQ) begin
        HOST_IO_FWD <= next_host_io_fwd;  // see [RULE14]
      end
      if (PCI_IO_REQ) begin
        PCI_IO_FWD <= next_pci_io_fwd;  // see [RULE14]
      end
    end
  end

  // Mirrors of configuration state
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      GAP_ENABLE  <= 1'b0;
      FB_SIZE_MB  <= 6'h00;
      FB_SIZE_BAD <= 1'b0;
    end else begin
      GAP_ENABLE  <= gap_en & gap_range_on;  // see [RULE4] [RULE6]
      FB_SIZE_MB  <= fb_mb;  // see [RULE1]
      FB_SIZE_BAD <= fb_bad;
    end
  end

endmodule

// File: tb/brd_range_decode_asserts.sv
// Port checker for the range decode block, bound to its top module.
// Assumes one clock domain with a synchronous active high reset.
`timescale 1ns/1ps
module brd_chk (
  input logic        CLK_SYS,
  input logic        RESET,
  input logic        CFG_RD,
  input logic        CFG_RACK,
  input logic        HOST_MEM_REQ,
  input logic [35:0] HOST_MEM_ADDR,
  input logic        HOST_MEM_DONE,
  input logic        HOST_MEM_HIT,
  input logic        HOST_MEM_FWD,
  input logic        PCI_MEM_REQ,
  input logic [35:0] PCI_MEM_ADDR,
  input logic        PCI_MEM_HIT,
  input logic        PCI_MEM_FWD,
  input logic        HOST_IO_REQ,
  input logic [15:0] HOST_IO_ADDR,
  input logic        HOST_IO_FWD,
  input logic        PCI_IO_REQ,
  input logic [15:0] PCI_IO_ADDR,
  input logic        PCI_IO_DONE,
  input logic        PCI_IO_FWD,
  input logic        GAP_ENABLE,
  input logic [5:0]  FB_SIZE_MB,
  input logic        FB_SIZE_BAD
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // Steps of a read and of paired decode requests
  sequence s_rd_answer;
    CFG_RD ##1 CFG_RACK;
  endsequence
  sequence s_same_mem;
    HOST_MEM_REQ && PCI_MEM_REQ && HOST_MEM_ADDR == PCI_MEM_ADDR;
  endsequence
  sequence s_same_io;
    HOST_IO_REQ && PCI_IO_REQ && HOST_IO_ADDR == PCI_IO_ADDR;
  endsequence
  chk_cfg_rack: assert property (CFG_RD |-> s_rd_answer)
    else $error("read answer missing");
  chk_mem_done: assert property (!$past(RESET) |->
    HOST_MEM_DONE == $past(HOST_MEM_REQ)) else $error("mem done wrong");
  chk_io_done: assert property (!$past(RESET) |->
    PCI_IO_DONE == $past(PCI_IO_REQ)) else $error("io done wrong");
  chk_host_gap_fwd: assert property (HOST_MEM_DONE |->
    HOST_MEM_FWD == (HOST_MEM_HIT && GAP_ENABLE)) else $error("host gap");
  chk_pci_gap_fwd: assert property (s_same_mem |=>
    PCI_MEM_FWD == (PCI_MEM_HIT && !GAP_ENABLE)) else $error("pci gap");
  chk_gap_range: assert property (s_same_mem |=>
    HOST_MEM_HIT == PCI_MEM_HIT) else $error("gap hit differs");
  chk_io_split: assert property (s_same_io |=>
    HOST_IO_FWD != PCI_IO_FWD) else $error("io sides agree");
  chk_io_hold: assert property (!HOST_IO_REQ |=> $stable(HOST_IO_FWD))
    else $error("io forward moved");
  chk_fb_legal: assert property (!$past(RESET) |-> (FB_SIZE_BAD ?
    FB_SIZE_MB == 6'h00 : FB_SIZE_MB inside {6'h01, 6'h02, 6'h04, 6'h08,
    6'h10, 6'h20})) else $error("frame size code");
endmodule

bind brd_range_decode brd_chk u_brd_chk (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .CFG_RD(CFG_RD), .CFG_RACK(CFG_RACK),
  .HOST_MEM_REQ(HOST_MEM_REQ), .HOST_MEM_ADDR(HOST_MEM_ADDR),
  .HOST_MEM_DONE(HOST_MEM_DONE), .HOST_MEM_HIT(HOST_MEM_HIT),
  .HOST_MEM_FWD(HOST_MEM_FWD), .PCI_MEM_REQ(PCI_MEM_REQ),
  .PCI_MEM_ADDR(PCI_MEM_ADDR), .PCI_MEM_HIT(PCI_MEM_HIT),
  .PCI_MEM_FWD(PCI_MEM_FWD), .HOST_IO_REQ(HOST_IO_REQ),
  .HOST_IO_ADDR(HOST_IO_ADDR), .HOST_IO_FWD(HOST_IO_FWD),
  .PCI_IO_REQ(PCI_IO_REQ), .PCI_IO_ADDR(PCI_IO_ADDR),
  .PCI_IO_DONE(PCI_IO_DONE), .PCI_IO_FWD(PCI_IO_FWD),
  .GAP_ENABLE(GAP_ENABLE), .FB_SIZE_MB(FB_SIZE_MB),
  .FB_SIZE_BAD(FB_SIZE_BAD)
);

// File: tb/brd_sw_model.sv
// Configuration software model: writes and reads bridge registers.
// Assumes the bridge samples strobes on the rising clock edge.
`timescale 1ns/1ps
`include "brd_defs.vh"
module brd_sw_model (
  input  logic        clk,
  output logic        cfg_wr,
  output logic        cfg_rd,
  output logic [7:0]  cfg_addr,
  output logic [31:0] cfg_wdata
);
  // Bus idle at time zero
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h00000000;
  end
  // Reserved gap bits always go out as zero
  function automatic logic [31:0] keep(logic [7:0] a, logic [31:0] d);
    case (a)
      8'h88: return d & `BRD_MASK_GAP_START;
      8'h8C: return d & `BRD_MASK_GAP_END;
      default: return d;
    endcase
  endfunction
  // One write, then bus released with scrambled lines
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = keep(a, d);
    @(posedge clk) #1;
    cfg_wr = 1'b0;
    cfg_addr = ~cfg_addr;
    cfg_wdata = ~cfg_wdata;
    @(posedge clk) #1;
  endtask
  // One read strobe
  task automatic rd(input logic [7:0] a);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge clk) #1;
    cfg_rd = 1'b0;
    cfg_addr = ~cfg_addr;
    @(posedge clk) #1;
  endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench: software model on config, bench on decode.
// Assumes both bridge roles share one config bus and the defines header.
`timescale 1ns/1ps
`include "brd_defs.vh"
module testbench;
  logic        clk, reset, rq, wr, rd, rk, hmd, hmh, hmf, pmd, pmh, pmf;
  logic        hid, hif, pid, pif, fbb, rk2, gon;
  logic [5:0]  fbm;
  wire  [5:0]  sd;
  wire  [3:0]  sdn;
  logic [7:0]  ca;
  logic [15:0] ia;
  logic [31:0] cw, rdt, rd2, gs, ge, w1, w2, s1, s2;
  logic [35:0] ma;
  logic [11:0] qd[$];
  logic [31:0] qc[$];
  logic [31:0] qs[$];
  int          fails, checks_done;
  logic [31:0] gv[3] = '{32'h80000010, 32'h00000010, 32'h80000000};
  logic [15:0] mt[4] = '{16'h000F, 16'h0010, 16'h0020, 16'h0021};
  logic [11:0] it[7] = '{12'h01F, 12'h020, 12'h035, 12'h040, 12'h041,
                         12'h080, 12'h081};
  logic [4:0]  fc[8] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F, 5'h02,
                         5'h10};
  logic [5:0]  fs[8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00,
                         6'h00};

  brd_range_decode #(.PRIMARY(1)) u_brd_range_decode (
    .CLK_SYS(clk), .RESET(reset), .CFG_WR(wr), .CFG_RD(rd), .CFG_ADDR(ca),
    .CFG_BE(4'hF), .CFG_WDATA(cw), .CFG_RDATA(rdt), .CFG_RACK(rk),
    .HOST_MEM_REQ(rq), .HOST_MEM_ADDR(ma), .HOST_MEM_DONE(hmd),
    .HOST_MEM_HIT(hmh), .HOST_MEM_FWD(hmf), .PCI_MEM_REQ(rq),
    .PCI_MEM_ADDR(ma), .PCI_MEM_DONE(pmd), .PCI_MEM_HIT(pmh),
    .PCI_MEM_FWD(pmf), .HOST_IO_REQ(rq), .HOST_IO_ADDR(ia),
    .HOST_IO_DONE(hid), .HOST_IO_FWD(hif), .PCI_IO_REQ(rq),
    .PCI_IO_ADDR(ia), .PCI_IO_DONE(pid), .PCI_IO_FWD(pif),
    .GAP_ENABLE(gon), .FB_SIZE_MB(fbm), .FB_SIZE_BAD(fbb));
  // Secondary bridge on the same configuration writes
  brd_range_decode #(.PRIMARY(0)) u_brd_range_decode_two (
    .CLK_SYS(clk), .RESET(reset), .CFG_WR(wr), .CFG_RD(rd),
    .CFG_ADDR(ca), .CFG_BE(4'hF), .CFG_WDATA(cw),
    .CFG_RDATA(rd2), .CFG_RACK(rk2), .HOST_MEM_REQ(rq),
    .HOST_MEM_ADDR(ma), .HOST_MEM_DONE(sdn[3]), .HOST_MEM_HIT(sd[5]),
    .HOST_MEM_FWD(sd[4]), .PCI_MEM_REQ(rq), .PCI_MEM_ADDR(ma),
    .PCI_MEM_DONE(sdn[2]), .PCI_MEM_HIT(sd[3]), .PCI_MEM_FWD(sd[2]),
    .HOST_IO_REQ(rq), .HOST_IO_ADDR(ia), .HOST_IO_DONE(sdn[1]),
    .HOST_IO_FWD(sd[1]), .PCI_IO_REQ(rq), .PCI_IO_ADDR(ia),
    .PCI_IO_DONE(sdn[0]), .PCI_IO_FWD(sd[0]), .GAP_ENABLE(),
    .FB_SIZE_MB(), .FB_SIZE_BAD());
  brd_sw_model u_brd_sw_model (.clk(clk), .cfg_wr(wr), .cfg_rd(rd),
    .cfg_addr(ca), .cfg_wdata(cw));

  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Expected decode from the shadow registers, p is the bridge role
  function automatic logic [5:0] expd(logic [35:0] a, logic [15:0] i,
                                      logic [31:0] v1, logic [31:0] v2,
                                      logic p);
    logic mh, h1, h2, hf;
    mh = gs[15:0] != 0 && a[35:20] >= gs[15:0];
    mh = mh && a[35:20] <= ge[15:0];
    h1 = i[15:4] >= v1[15:4] && i[15:4] <= v1[31:20];
    h2 = i[15:4] >= v2[15:4] && i[15:4] <= v2[31:20];
    hf = h1 ? v1[0] : (h2 ? v2[0] : p);
    return {mh, mh & gs[31], mh, mh & ~gs[31], hf, ~hf};
  endfunction
  // Decode request on all four groups, noting the result
  task automatic dec(input logic [35:0] a, input logic [15:0] i);
    rq = 1'b1;
    ma = a;
    ia = i;
    qd.push_back({expd(a, i, w1, w2, 1'b1), expd(a, i, s1, s2, 1'b0)});
    @(posedge clk) #1;
  endtask
  task automatic stop;
    rq = 1'b0;
    ma = ~ma;
    ia = ~ia;
    @(posedge clk) #1;
  endtask
  // Register access with shadow upkeep
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    u_brd_sw_model.wr(a, d);
    case (a)
      8'h88: gs = d;
      8'h8C: ge = d;
      8'h98: {w1, s1} = {d, d};
      8'hA0: {w2, s2} = {d, d};
      default: ;
    endcase
  endtask
  task automatic get(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] s);
    qc.push_back(e);
    qs.push_back(s);
    u_brd_sw_model.rd(a);
  endtask
  // Take the oldest note whenever an answer shows
  always @(negedge clk) begin
    if (hmd === 1'b1) begin
      check({hmd, pmd, hid, pid, sdn}, 8'hFF);
      check({hmh, hmf, pmh, pmf, hif, pif, sd}, qd.pop_front());
    end
    if (rk === 1'b1) begin
      check(rk2, 1'b1);
      check(rdt, qc.pop_front());
      check(rd2, qs.pop_front());
    end
  end
  // Watchdog
  initial begin
    #100000;
    fails++;
    test_done;
  end
  // Main sequence
  initial begin
    void'($urandom(73));
    reset = 1'b1;
    rq = 1'b0;
    ma = 36'h000000000;
    ia = 16'h0000;
    gs = 32'h00000000;
    ge = 32'h00000000;
    w1 = `BRD_RST_IO_PRIMARY;
    w2 = `BRD_RST_IO_PRIMARY;
    s1 = `BRD_RST_IO_SECOND;
    s2 = `BRD_RST_IO_SECOND;
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    get(8'h88, 32'h00000000, 32'h00000000);
    get(8'h8C, 32'h00000000, 32'h00000000);
    get(8'h98, 32'hFFF00001, 32'hFFF00000);
    get(8'hA0, 32'hFFF00001, 32'hFFF00000);
    get(8'h90, 32'h00000000, 32'h00000000);
    get(8'hAC, 32'h00000140, 32'h00000100);
    repeat (8) dec(36'({$urandom(), $urandom()}), 16'($urandom()));
    stop;
    put(8'h8C, 32'h00000020);
    foreach (gv[k]) begin
      put(8'h88, gv[k]);
      get(8'h88, gv[k], gv[k]);
      check(gon, gv[k][31] && gv[k][15:0] != 0);
      foreach (mt[j]) dec({mt[j], 20'h00001}, 16'($urandom()));
      stop;
    end
    for (int e = 0; e < 4; e++) begin
      put(8'h98, 32'h04000200 | e[0]);
      put(8'hA0, 32'h08000300 | e[1]);
      foreach (it[j]) dec(36'({$urandom(), $urandom()}),
                          {it[j], 4'($urandom())});
      stop;
    end
    foreach (fc[k]) begin
      put(8'h84, {27'h0000000, fc[k]});
      @(posedge clk) #1;
      check({fbb, fbm}, {fs[k] == 6'h00, fs[k]});
    end
    // Mid-run reset brings the windows and frame size back
    reset = 1'b1;
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    {gs, ge} = {`BRD_RST_GAP_START, `BRD_RST_GAP_END};
    {w1, w2} = {2{`BRD_RST_IO_PRIMARY}};
    {s1, s2} = {2{`BRD_RST_IO_SECOND}};
    get(8'h98, `BRD_RST_IO_PRIMARY, `BRD_RST_IO_SECOND);
    get(8'hA0, `BRD_RST_IO_PRIMARY, `BRD_RST_IO_SECOND);
    check({fbb, fbm}, 7'h01);
    foreach (it[j]) dec(36'({$urandom(), $urandom()}), {it[j], 4'h0});
    stop;
    repeat (2) @(posedge clk);
    check(qd.size() + qc.size() + qs.size(), 0);
    test_done;
  end
endmodule
